// ### pkg/ged_pkg.sv
package ged_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int unsigned GED_PINS = 81;
    localparam int unsigned GED_WORDS = 3;
    localparam int unsigned GED_WORD_BITS = 32;
    localparam int unsigned GED_SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] GED_ADDR_RISE0 = 32'h40e0_0030;
    localparam logic [31:0] GED_ADDR_RISE1 = 32'h40e0_0034;
    localparam logic [31:0] GED_ADDR_RISE2 = 32'h40e0_0038;
    localparam logic [31:0] GED_ADDR_FALL0 = 32'h40e0_003c;
    localparam logic [31:0] GED_ADDR_FALL1 = 32'h40e0_0040;
    localparam logic [31:0] GED_ADDR_FALL2 = 32'h40e0_0044;
    localparam logic [31:0] GED_ADDR_STAT0 = 32'h40e0_0048;
    localparam logic [31:0] GED_ADDR_STAT1 = 32'h40e0_004c;
    localparam logic [31:0] GED_ADDR_STAT2 = 32'h40e0_0050;
    localparam logic [31:0] GED_ADDR_MASK0 = 32'h40e0_00f0;
    localparam logic [31:0] GED_ADDR_MASK1 = 32'h40e0_00f4;
    localparam logic [31:0] GED_ADDR_MASK2 = 32'h40e0_00f8;

    // ------------------------------------------------------------
    // reset values and fixed field positions
    // ------------------------------------------------------------
    localparam logic [31:0] GED_WORD_RESET = 32'h0000_0000;
    localparam int unsigned GED_OWN_IRQ_PIN0 = 0;
    localparam int unsigned GED_OWN_IRQ_PIN1 = 1;
    localparam int unsigned GED_GROUP_LOW_PIN = 2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned GED_CLK_PERIOD_NS = 100;
    localparam int unsigned GED_MIN_PULSE_NS = 1000;
    localparam int unsigned GED_MIN_PULSE_CYC =
        (GED_MIN_PULSE_NS + GED_CLK_PERIOD_NS - 1) / GED_CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [GED_WORDS-1:0][GED_WORD_BITS-1:0] ged_bank_t;

    typedef enum logic [2:0] {
        GED_REG_RISE,
        GED_REG_FALL,
        GED_REG_STAT,
        GED_REG_MASK,
        GED_REG_NONE
    } ged_kind_t;

    typedef struct packed {
        ged_kind_t kind;
        logic [1:0] idx;
    } ged_sel_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } ged_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ged_apb_rsp_t;

endpackage

// ### logic/ged_edge_sync.sv
module ged_edge_sync #(
    parameter int unsigned WIDTH = 81
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] rise_seen,
    output logic [WIDTH-1:0] fall_seen
);
    import ged_pkg::*;

    // ------------------------------------------------------------
    // two-stage synchroniser plus one history stage
    // ------------------------------------------------------------
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] prev_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;
    logic [WIDTH-1:0] nxt_prev;

    // meta_ff feeds sync_ff only; edges are judged on settled samples
    always_comb begin
        nxt_meta = pin_in;
        nxt_sync = meta_ff;
        nxt_prev = sync_ff;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            prev_ff <= nxt_prev;
        end
    end

    // a level held for one clock is always seen, far below the
    // guaranteed pulse width
    assign rise_seen = sync_ff & ~prev_ff;
    assign fall_seen = ~sync_ff & prev_ff;

endmodule

// ### logic/ged_unit.sv
// Local design decision: register access over APB.
module ged_unit #(
    parameter int unsigned PIN_COUNT = ged_pkg::GED_PINS,
    parameter logic [95:0] WAKE_SEL = 96'h0000_0000_0000_0000_0000_ffff
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [PIN_COUNT-1:0] gpio_pin_in,
    input wire ged_pkg::ged_apb_req_t apb_req,
    output ged_pkg::ged_apb_rsp_t apb_rsp,
    output logic irq,
    output logic irq_pin0,
    output logic irq_pin1,
    output logic irq_group,
    output logic wake_req
);
    import ged_pkg::*;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    localparam int unsigned BITS = GED_WORDS * GED_WORD_BITS;
    localparam int unsigned LAST_WORD_BITS =
        PIN_COUNT - (GED_WORDS - 1) * GED_WORD_BITS;

    // three words hold the pins; fewer pins would leave a word empty
    if (PIN_COUNT <= (GED_WORDS - 1) * GED_WORD_BITS ||
            PIN_COUNT > BITS) begin : g_bad_pins
        $error("PIN_COUNT must lie in 65..96");
    end
    // the detector needs only one stable sample per level
    if (GED_MIN_PULSE_CYC < 1) begin : g_bad_pulse
        $error("minimum pulse shorter than one clock");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    localparam logic [BITS-1:0] PIN_VALID =
        {BITS{1'b1}} >> (BITS - PIN_COUNT);
    localparam ged_bank_t BANK_VALID = PIN_VALID;
    localparam logic [BITS-1:0] WAKE_VALID = WAKE_SEL & PIN_VALID;

    // reserved bits above the last pin are neither stored nor read
    function automatic logic [31:0] word_mask(input logic [1:0] idx);
        word_mask = BANK_VALID[idx];
    endfunction

    function automatic ged_sel_t decode(input logic [31:0] addr);
        ged_sel_t s;
        s.kind = GED_REG_NONE;
        s.idx = 2'd0;
        case (addr)
            GED_ADDR_RISE0: s = '{GED_REG_RISE, 2'd0};
            GED_ADDR_RISE1: s = '{GED_REG_RISE, 2'd1};
            GED_ADDR_RISE2: s = '{GED_REG_RISE, 2'd2};
            GED_ADDR_FALL0: s = '{GED_REG_FALL, 2'd0};
            GED_ADDR_FALL1: s = '{GED_REG_FALL, 2'd1};
            GED_ADDR_FALL2: s = '{GED_REG_FALL, 2'd2};
            GED_ADDR_STAT0: s = '{GED_REG_STAT, 2'd0};
            GED_ADDR_STAT1: s = '{GED_REG_STAT, 2'd1};
            GED_ADDR_STAT2: s = '{GED_REG_STAT, 2'd2};
            GED_ADDR_MASK0: s = '{GED_REG_MASK, 2'd0};
            GED_ADDR_MASK1: s = '{GED_REG_MASK, 2'd1};
            GED_ADDR_MASK2: s = '{GED_REG_MASK, 2'd2};
            default: s = '{GED_REG_NONE, 2'd0};
        endcase
        return s;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ged_bank_t rise_ff;
    ged_bank_t fall_ff;
    ged_bank_t stat_ff;
    ged_bank_t mask_ff;
    ged_bank_t nxt_rise;
    ged_bank_t nxt_fall;
    ged_bank_t nxt_stat;
    ged_bank_t nxt_mask;
    ged_apb_rsp_t rsp_ff;
    ged_apb_rsp_t nxt_rsp;
    logic irq_ff;
    logic irq_pin0_ff;
    logic irq_pin1_ff;
    logic irq_group_ff;
    logic wake_ff;
    logic nxt_irq;
    logic nxt_irq_pin0;
    logic nxt_irq_pin1;
    logic nxt_irq_group;
    logic nxt_wake;

    logic [PIN_COUNT-1:0] rise_seen;
    logic [PIN_COUNT-1:0] fall_seen;
    logic [BITS-1:0] rise_flat;
    logic [BITS-1:0] fall_flat;
    logic [BITS-1:0] stat_next_flat;
    logic [BITS-1:0] mask_next_flat;
    logic [PIN_COUNT-1:0] hit;
    ged_bank_t set_bank;
    ged_sel_t sel;
    logic access;
    logic commit_wr;

    // ------------------------------------------------------------
    // pin sampling and edge detection
    // ------------------------------------------------------------
    ged_edge_sync #(
        .WIDTH(PIN_COUNT)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .pin_in(gpio_pin_in),
        .rise_seen(rise_seen),
        .fall_seen(fall_seen)
    );

    assign rise_flat = rise_ff;
    assign fall_flat = fall_ff;

    always_comb begin
        hit = (rise_seen & rise_flat[PIN_COUNT-1:0])
            | (fall_seen & fall_flat[PIN_COUNT-1:0]);
        set_bank = BITS'(hit);
    end

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // pready is registered, so every access phase lasts two cycles;
    // the write lands on the edge where pready is sampled high
    always_comb begin
        sel = decode(apb_req.paddr);
        access = apb_req.psel & apb_req.penable;
        commit_wr = access & rsp_ff.pready & apb_req.pwrite;
    end

    always_comb begin
        nxt_rsp = '0;
        if (access && !rsp_ff.pready) begin
            nxt_rsp.pready = 1'b1;
            nxt_rsp.pslverr = (sel.kind == GED_REG_NONE);
            if (!apb_req.pwrite) begin
                case (sel.kind)
                    GED_REG_RISE: nxt_rsp.prdata = rise_ff[sel.idx];
                    GED_REG_FALL: nxt_rsp.prdata = fall_ff[sel.idx];
                    GED_REG_STAT: nxt_rsp.prdata = stat_ff[sel.idx];
                    GED_REG_MASK: nxt_rsp.prdata = mask_ff[sel.idx];
                    default: nxt_rsp.prdata = GED_WORD_RESET;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_comb begin
        nxt_rise = rise_ff;
        nxt_fall = fall_ff;
        nxt_mask = mask_ff;
        nxt_stat = stat_ff;
        if (commit_wr) begin
            case (sel.kind)
                GED_REG_RISE:
                    nxt_rise[sel.idx] =
                        apb_req.pwdata & word_mask(sel.idx);
                GED_REG_FALL:
                    nxt_fall[sel.idx] =
                        apb_req.pwdata & word_mask(sel.idx);
                GED_REG_MASK:
                    nxt_mask[sel.idx] = apb_req.pwdata & word_mask(sel.idx);
                GED_REG_STAT:
                    nxt_stat[sel.idx] =
                        stat_ff[sel.idx] & ~apb_req.pwdata;
                default: nxt_stat = stat_ff;
            endcase
        end
        // a fresh edge beats a clear written in the same cycle
        nxt_stat = (nxt_stat | set_bank) & BANK_VALID;
    end

    // ------------------------------------------------------------
    // requests to interrupt controller and wake logic
    // ------------------------------------------------------------
    // taken from next state so requests move with the status bits
    always_comb begin
        stat_next_flat = nxt_stat;
        mask_next_flat = nxt_mask;
        nxt_irq = |(stat_next_flat & mask_next_flat);
        nxt_irq_pin0 = stat_next_flat[GED_OWN_IRQ_PIN0];
        nxt_irq_pin1 = stat_next_flat[GED_OWN_IRQ_PIN1];
        nxt_irq_group =
            |stat_next_flat[PIN_COUNT-1:GED_GROUP_LOW_PIN];
        nxt_wake = |(stat_next_flat & WAKE_VALID);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rise_ff <= {GED_WORDS{GED_WORD_RESET}};
            fall_ff <= {GED_WORDS{GED_WORD_RESET}};
            stat_ff <= {GED_WORDS{GED_WORD_RESET}};
            mask_ff <= {GED_WORDS{GED_WORD_RESET}};
            rsp_ff <= '0;
            irq_ff <= 1'b0;
            irq_pin0_ff <= 1'b0;
            irq_pin1_ff <= 1'b0;
            irq_group_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            rise_ff <= nxt_rise;
            fall_ff <= nxt_fall;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            rsp_ff <= nxt_rsp;
            irq_ff <= nxt_irq;
            irq_pin0_ff <= nxt_irq_pin0;
            irq_pin1_ff <= nxt_irq_pin1;
            irq_group_ff <= nxt_irq_group;
            wake_ff <= nxt_wake;
        end
    end

    assign apb_rsp = rsp_ff;
    assign irq = irq_ff;
    assign irq_pin0 = irq_pin0_ff;
    assign irq_pin1 = irq_pin1_ff;
    assign irq_group = irq_group_ff;
    assign wake_req = wake_ff;

endmodule

// ### tb/ged_unit_chk.sv
module ged_unit_chk #(
    parameter int unsigned PIN_COUNT = 81
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [PIN_COUNT-1:0] gpio_pin_in,
    input wire ged_pkg::ged_apb_req_t apb_req,
    input wire ged_pkg::ged_apb_rsp_t apb_rsp,
    input wire logic irq,
    input wire logic irq_pin0,
    input wire logic irq_pin1,
    input wire logic irq_group,
    input wire logic wake_req
);
    timeunit 1ns;
    timeprecision 1ns;
    import ged_pkg::*;
    logic wr_done;
    // status may only drop at the edge that commits a write
    assign wr_done = apb_req.psel & apb_req.penable & apb_req.pwrite
        & apb_rsp.pready;
    default clocking cb @(posedge clk); endclocking
    // ----
    // assertions
    // ----
    a_pin0_edge: assert property (disable iff (srst)
        $rose(irq_pin0) |-> $past(gpio_pin_in[0], 3)
        != $past(gpio_pin_in[0], 4))
        else $error("irq_pin0 rose without a pin 0 edge");
    a_pin1_edge: assert property (disable iff (srst)
        $rose(irq_pin1) |-> $past(gpio_pin_in[1], 3)
        != $past(gpio_pin_in[1], 4))
        else $error("irq_pin1 rose without a pin 1 edge");
    a_group_edge: assert property (disable iff (srst)
        $rose(irq_group) |-> $past(gpio_pin_in[PIN_COUNT-1:2], 3)
        != $past(gpio_pin_in[PIN_COUNT-1:2], 4))
        else $error("irq_group rose without a group pin edge");
    a_pin0_sticky: assert property (disable iff (srst)
        $fell(irq_pin0) |-> $past(wr_done))
        else $error("irq_pin0 dropped without a write");
    a_group_sticky: assert property (disable iff (srst)
        $fell(irq_group) |-> $past(wr_done))
        else $error("irq_group dropped without a write");
    a_irq_source: assert property (disable iff (srst)
        irq |-> irq_pin0 || irq_pin1 || irq_group)
        else $error("irq high with no status bit set");
    a_wake_source: assert property (disable iff (srst)
        wake_req |-> irq_pin0 || irq_pin1 || irq_group)
        else $error("wake_req high with no status bit set");
    a_rsvd_read: assert property (disable iff (srst)
        apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == GED_ADDR_RISE2
        |-> apb_rsp.prdata[31:17] == 15'h0000 && !apb_rsp.pslverr)
        else $error("reserved bits of third word read nonzero");
    a_reset_idle: assert property (
        srst |=> !apb_rsp.pready && !irq && !irq_group && !wake_req)
        else $error("outputs active after reset");
    c_pin0: cover property ($rose(irq_pin0));
    c_group: cover property ($rose(irq_group));
    c_slverr: cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule

bind ged_unit ged_unit_chk #(.PIN_COUNT(PIN_COUNT)) ged_unit_chk_i (
    .clk(clk), .srst(srst), .gpio_pin_in(gpio_pin_in), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .irq(irq), .irq_pin0(irq_pin0), .irq_pin1(irq_pin1),
    .irq_group(irq_group), .wake_req(wake_req));

// ### tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ged_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [80:0] pins = '0;
    ged_apb_req_t req = '0;
    ged_apb_rsp_t rsp;
    logic irq, irq_pin0, irq_pin1, irq_group, wake_req;
    logic [31:0] q;
    logic e;
    logic msk = 1'b1;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    // pin, then {rise enable, fall enable, direction up}
    int cp [9] = '{0, 1, 40, 80, 5, 64, 33, 31, 63};
    logic [2:0] cm [9] = '{3'b101, 3'b010, 3'b111, 3'b110, 3'b100,
        3'b011, 3'b001, 3'b101, 3'b010};
    logic [31:0] regs [12] = '{GED_ADDR_RISE0, GED_ADDR_RISE1,
        GED_ADDR_RISE2, GED_ADDR_FALL0, GED_ADDR_FALL1, GED_ADDR_FALL2,
        GED_ADDR_STAT0, GED_ADDR_STAT1, GED_ADDR_STAT2, GED_ADDR_MASK0,
        GED_ADDR_MASK1, GED_ADDR_MASK2};

    always #50 clk = ~clk;

    ged_unit ged_unit_i (.clk(clk), .srst(srst), .gpio_pin_in(pins),
        .apb_req(req), .apb_rsp(rsp), .irq(irq), .irq_pin0(irq_pin0),
        .irq_pin1(irq_pin1), .irq_group(irq_group), .wake_req(wake_req));

    // ----
    // access and compare tasks
    // ----
    task automatic print_verdict();
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] x);
        num_checks++;
        if (seen !== x) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                $time, seen, x);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (n > 20) begin
                n_fail++;
                print_verdict();
            end
        end while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        check(q, x);
    endtask

    // enables are written while the pin is quiet, then one transition
    task automatic edge_case(input int p, input logic r, input logic f,
        input logic up);
        logic [31:0] b;
        logic [31:0] ofs;
        logic hit;
        ofs = 32'(4 * (p / 32));
        b = 32'h0000_0001 << (p % 32);
        hit = up ? r : f;
        @(posedge clk);
        pins[p] <= !up;
        repeat (4) @(posedge clk);
        wr(GED_ADDR_RISE0 + ofs, r ? b : 32'h0000_0000);
        wr(GED_ADDR_FALL0 + ofs, f ? b : 32'h0000_0000);
        wr(GED_ADDR_STAT0 + ofs, b);
        @(posedge clk);
        pins[p] <= up;
        repeat (5) @(posedge clk);
        rd_chk(GED_ADDR_STAT0 + ofs, hit ? b : 32'h0000_0000);
        check(32'({irq, irq_pin0, irq_pin1, irq_group, wake_req}), 32'({hit
            & msk, hit & (p == 0), hit & (p == 1), hit & (p > 1), hit
            & (p < 16)}));
        wr(GED_ADDR_STAT0 + ofs, 32'h0000_0000);
        rd_chk(GED_ADDR_STAT0 + ofs, hit ? b : 32'h0000_0000);
        wr(GED_ADDR_STAT0 + ofs, b);
        rd_chk(GED_ADDR_STAT0 + ofs, 32'h0000_0000);
        check(32'({irq, irq_pin0, irq_pin1, irq_group}), 32'h0);
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_fail++;
            print_verdict();
        end
    end

    // ----
    // main sequence
    // ----
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        foreach (regs[i]) begin
            rd_chk(regs[i], 32'h0000_0000);
        end
        wr(GED_ADDR_RISE1, 32'ha5a5_5a5a);
        rd_chk(GED_ADDR_RISE1, 32'ha5a5_5a5a);
        wr(GED_ADDR_FALL2, 32'h0001_2345);
        rd_chk(GED_ADDR_FALL2, 32'h0001_2345);
        apb(1'b0, 32'h40e0_0060, 32'h0000_0000);
        check(q, 32'h0000_0000);
        check(32'(e), 32'h0000_0001);
        wr(GED_ADDR_MASK0, 32'hffff_ffff);
        wr(GED_ADDR_MASK1, 32'hffff_ffff);
        wr(GED_ADDR_MASK2, 32'h0001_ffff);
        foreach (cp[i]) begin
            edge_case(cp[i], cm[i][2], cm[i][1], cm[i][0]);
        end
        msk = 1'b0;
        wr(GED_ADDR_MASK0, 32'h0000_0000);
        edge_case(3, 1'b1, 1'b0, 1'b1);
        wr(GED_ADDR_RISE2, 32'h0000_0000);
        wr(GED_ADDR_FALL2, 32'h0000_0040);
        pins[70] <= 1'b1;
        repeat (10) @(posedge clk);
        pins[70] <= 1'b0;
        repeat (5) @(posedge clk);
        rd_chk(GED_ADDR_STAT2, 32'h0000_0040);
        // reset in mid-run must wipe enables and pending status
        wr(GED_ADDR_RISE0, 32'hffff_ffff);
        @(posedge clk);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd_chk(GED_ADDR_RISE0, 32'h0000_0000);
        rd_chk(GED_ADDR_FALL2, 32'h0000_0000);
        rd_chk(GED_ADDR_STAT2, 32'h0000_0000);
        check(32'({irq, irq_group}), 32'h0000_0000);
        print_verdict();
    end
endmodule
